// ### src/hcc_defs.vh
// hcc_defs.vh - register offsets, field positions and reset values for the
// link code and channel configuration block.
// assumes: included by bare name from the design file, nothing else needed.
`ifndef HCC_DEFS_VH
`define HCC_DEFS_VH

// ---------------------------------------------------------------------
// register offsets on the parallel control port
// ---------------------------------------------------------------------
`define HCC_ADDR_TX_CODE_CTRL   8'h07
`define HCC_ADDR_TX_FIFO_PORT   8'h08
`define HCC_ADDR_RX_CHAN_CTRL   8'h90
`define HCC_ADDR_RX_BIT_SUPP    8'h91

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define HCC_SEND_CODE_TRIGGER   7
`define HCC_LINK_SOURCE_SELECT  6
`define HCC_CODE_WORD_LAST_BIT  5
`define HCC_CODE_WORD_FIRST_BIT 0
`define HCC_RX_CHAN_MODE_EN     7
`define HCC_RX_CHAN_SEL_MODE    5
`define HCC_RX_CHAN_NUM_MSB     4
`define HCC_RX_CHAN_NUM_LSB     0

// ---------------------------------------------------------------------
// reset values, masks and the last code bit index
// ---------------------------------------------------------------------
`define HCC_RST_TX_CODE_CTRL    8'h00
`define HCC_RST_RX_CHAN_CTRL    8'h00
`define HCC_RST_RX_BIT_SUPP     8'h00
`define HCC_RX_CHAN_CTRL_MASK   8'hbf
`define HCC_CODE_LAST_INDEX     3'h5

`endif

// ### src/hcc_link_cfg.v
// hcc_link_cfg.v - configuration registers of the data-link controller:
// transmit code sending, transmit link source, transmit fifo write port
// and receive channel mapping with per-bit suppression.
// assumes: one clock, synchronous active-low reset, single-cycle read and
// write strobes on the parallel control port, and bit strobes from the
// framer timing that are one clock wide.
`include "hcc_defs.vh"

module hcc_link_cfg #(
  parameter CODE_REPEAT = 8'd10           // code words sent per trigger
) (
  input  wire        CLK_I,               // 25 mhz framer clock
  input  wire        RST_N_I,             // synchronous reset, active low
  input  wire [7:0]  ADDR_I,              // register address
  input  wire [7:0]  WDATA_I,             // write data
  input  wire        WR_I,                // write strobe, one cycle
  input  wire        RD_I,                // read strobe, one cycle
  output reg  [7:0]  RDATA_O,             // read data, held until next read
  output reg  [7:0]  FIFO_DATA_O,         // byte for the transmit fifo
  output reg         FIFO_WR_O,           // one-cycle fifo write pulse
  input  wire        TX_BIT_STB_I,        // one pulse per link bit time
  input  wire        EXT_LINK_DATA_I,     // external link data input
  input  wire        HDLC_TX_DATA_I,      // bit from hdlc engine
  output reg         HDLC_TX_ADV_O,       // hdlc bit consumed, pulse
  output reg         TX_LINK_DATA_O,      // bit placed on the data link
  output reg         CODE_ACTIVE_O,       // code send in progress
  input  wire        RX_FDL_BIT_I,        // received data link bit
  input  wire        RX_FDL_STB_I,        // strobe for data link bit
  input  wire        RX_DATA_I,           // received line data bit
  input  wire        RX_BIT_STB_I,        // strobe for line data bit
  input  wire [4:0]  RX_CHAN_I,           // current channel number
  input  wire [2:0]  RX_BIT_POS_I,        // bit in channel, 0 is bit 1
  input  wire [23:0] RX_CHAN_BLOCK_I,     // channel block selection set
  output reg         RX_HDLC_DATA_O,      // bit for receive hdlc engine
  output reg         RX_HDLC_STB_O        // strobe for that bit
);

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  reg [7:0] tx_link_code_control;         // trigger, source, code word
  reg [7:0] rx_hdlc_channel_control;      // enable, mode, channel number
  reg [7:0] rx_hdlc_bit_suppress;         // per-bit suppress
  reg [2:0] code_bit;                     // index of code bit on the link
  reg [7:0] code_left;                    // code words still to send
  reg       code_start;                   // pulse: trigger went 0 to 1

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // true when the write strobe targets the given offset
  function wr_hit;
    input [7:0] addr;
    input       wr;
    input [7:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  wire wr_code = wr_hit(ADDR_I, WR_I, `HCC_ADDR_TX_CODE_CTRL);
  wire wr_fifo = wr_hit(ADDR_I, WR_I, `HCC_ADDR_TX_FIFO_PORT);
  wire wr_chan = wr_hit(ADDR_I, WR_I, `HCC_ADDR_RX_CHAN_CTRL);
  wire wr_supp = wr_hit(ADDR_I, WR_I, `HCC_ADDR_RX_BIT_SUPP);

  // -------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------
  // software writes; the trigger edge is taken from old and new value
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      tx_link_code_control    <= `HCC_RST_TX_CODE_CTRL;
      rx_hdlc_channel_control <= `HCC_RST_RX_CHAN_CTRL;
      rx_hdlc_bit_suppress    <= `HCC_RST_RX_BIT_SUPP;
      code_start              <= 1'b0;
    end else begin
      code_start <= wr_code && WDATA_I[`HCC_SEND_CODE_TRIGGER] &&
                    !tx_link_code_control[`HCC_SEND_CODE_TRIGGER];
      if (wr_code) begin
        tx_link_code_control <= WDATA_I;
      end
      if (wr_chan) begin
        // unassigned bit 6 is kept at zero
        rx_hdlc_channel_control <= WDATA_I & `HCC_RX_CHAN_CTRL_MASK;
      end
      if (wr_supp) begin
        rx_hdlc_bit_suppress <= WDATA_I;
      end
    end
  end

  // -------------------------------------------------------------------
  // read port and fifo write port
  // -------------------------------------------------------------------
  // read data is captured on the read strobe; fifo port reads as zero
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RDATA_O     <= 8'h00;
      FIFO_DATA_O <= 8'h00;
      FIFO_WR_O   <= 1'b0;
    end else begin
      // byte passed with bit order kept
      FIFO_WR_O <= wr_fifo;
      if (wr_fifo) begin
        FIFO_DATA_O <= WDATA_I;
      end
      if (RD_I) begin
        case (ADDR_I)
          `HCC_ADDR_TX_CODE_CTRL: begin
            RDATA_O <= tx_link_code_control;
          end
          `HCC_ADDR_RX_CHAN_CTRL: begin
            RDATA_O <= rx_hdlc_channel_control;
          end
          `HCC_ADDR_RX_BIT_SUPP: begin
            RDATA_O <= rx_hdlc_bit_suppress;
          end
          default: begin
            RDATA_O <= 8'h00;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // transmit code sequencer
  // -------------------------------------------------------------------
  wire internal_src = tx_link_code_control[`HCC_LINK_SOURCE_SELECT];
  wire code_bit_now = tx_link_code_control[code_bit];

  // walks the code word once per repeat, one bit per link bit time
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CODE_ACTIVE_O <= 1'b0;
      code_bit      <= 3'h0;
      code_left     <= 8'h00;
    end else if (code_start) begin
      // a new trigger restarts the word from its first bit
      CODE_ACTIVE_O <= 1'b1;
      code_bit      <= 3'h0;
      code_left     <= CODE_REPEAT;
    end else if (CODE_ACTIVE_O && TX_BIT_STB_I) begin
      // bit 0 first, bit 5 last
      if (code_bit == `HCC_CODE_LAST_INDEX) begin
        code_bit <= 3'h0;
        if (code_left <= 8'h01) begin
          CODE_ACTIVE_O <= 1'b0;
          code_left     <= 8'h00;
        end else begin
          code_left <= code_left - 8'h01;
        end
      end else begin
        code_bit <= code_bit + 3'h1;
      end
    end
  end

  // -------------------------------------------------------------------
  // transmit link multiplexer
  // -------------------------------------------------------------------
  // picks the source of each link bit on the bit strobe
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      TX_LINK_DATA_O <= 1'b1;
      HDLC_TX_ADV_O  <= 1'b0;
    end else begin
      HDLC_TX_ADV_O <= 1'b0;
      if (TX_BIT_STB_I) begin
        if (!internal_src) begin
          TX_LINK_DATA_O <= EXT_LINK_DATA_I;
        end else if (CODE_ACTIVE_O) begin
          TX_LINK_DATA_O <= code_bit_now;
        end else begin
          TX_LINK_DATA_O <= HDLC_TX_DATA_I;
          HDLC_TX_ADV_O  <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // receive channel mapping
  // -------------------------------------------------------------------
  wire       chan_mode_en = rx_hdlc_channel_control[`HCC_RX_CHAN_MODE_EN];
  wire       chan_sel_blk = rx_hdlc_channel_control[`HCC_RX_CHAN_SEL_MODE];
  wire [4:0] chan_num = rx_hdlc_channel_control[`HCC_RX_CHAN_NUM_MSB:
                                                `HCC_RX_CHAN_NUM_LSB];
  // channels outside the 24-slot set never match the block
  wire       blk_hit  = (RX_CHAN_I < 5'd24) && RX_CHAN_BLOCK_I[RX_CHAN_I];
  wire       chan_hit = chan_sel_blk ? blk_hit : (RX_CHAN_I == chan_num);
  wire       bit_keep = !rx_hdlc_bit_suppress[RX_BIT_POS_I];

  // hands the chosen bits to the receive hdlc engine
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RX_HDLC_DATA_O <= 1'b0;
      RX_HDLC_STB_O  <= 1'b0;
    end else if (!chan_mode_en) begin
      RX_HDLC_STB_O <= RX_FDL_STB_I;
      if (RX_FDL_STB_I) begin
        RX_HDLC_DATA_O <= RX_FDL_BIT_I;
      end
    end else begin
      RX_HDLC_STB_O <= RX_BIT_STB_I && chan_hit && bit_keep;
      if (RX_BIT_STB_I && chan_hit && bit_keep) begin
        RX_HDLC_DATA_O <= RX_DATA_I;
      end
    end
  end

endmodule

// ### test/hcc_link_cfg_assertions.sv
// checker for the link code and channel configuration block
// assumes: bound to hcc_link_cfg, one clock, reset low sampled on CLK_I
module hcc_link_cfg_assertions (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire [7:0] FIFO_DATA_O,
  input wire       FIFO_WR_O,
  input wire       TX_BIT_STB_I,
  input wire       EXT_LINK_DATA_I,
  input wire       HDLC_TX_DATA_I,
  input wire       HDLC_TX_ADV_O,
  input wire       TX_LINK_DATA_O,
  input wire       CODE_ACTIVE_O,
  input wire       RX_FDL_STB_I,
  input wire       RX_FDL_BIT_I,
  input wire       RX_HDLC_STB_O,
  input wire       RX_HDLC_DATA_O
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // shadow registers
  // ---------------------------------------------------------------
  logic [7:0] cc;                                   // code control copy
  logic [7:0] rc;                                   // rx channel copy
  wire        w7 = WR_I && ADDR_I == 8'h07;         // code control write
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cc <= 8'h00;
      rc <= 8'h00;
    end else if (w7) begin
      cc <= WDATA_I;
    end else if (WR_I && ADDR_I == 8'h90) begin
      rc <= WDATA_I;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  fifo_byte_a: assert property (WR_I && ADDR_I == 8'h08 |=>
    FIFO_WR_O && FIFO_DATA_O == $past(WDATA_I)) else $error("fifo byte");
  fifo_quiet_a: assert property (!(WR_I && ADDR_I == 8'h08) |=>
    !FIFO_WR_O) else $error("stray fifo pulse");
  code_start_a: assert property (w7 && WDATA_I[7] && !cc[7]
    |-> ##2 CODE_ACTIVE_O) else $error("code not started");
  no_retrigger_a: assert property (w7 && WDATA_I[7] && cc[7]
    && !$rose(cc[7]) && !CODE_ACTIVE_O |-> ##2 !CODE_ACTIVE_O)
    else $error("code retriggered");
  ext_source_a: assert property (TX_BIT_STB_I && !cc[6] && !w7
    |=> TX_LINK_DATA_O == $past(EXT_LINK_DATA_I)) else $error("ext bit");
  hdlc_source_a: assert property (TX_BIT_STB_I && cc[6]
    && !CODE_ACTIVE_O && !w7 && !$past(w7) |=> HDLC_TX_ADV_O &&
    TX_LINK_DATA_O == $past(HDLC_TX_DATA_I)) else $error("hdlc bit");
  code_holds_a: assert property (CODE_ACTIVE_O |=> !HDLC_TX_ADV_O)
    else $error("hdlc advanced during code");
  rx_link_a: assert property (RX_FDL_STB_I && !rc[7] |=>
    RX_HDLC_STB_O && RX_HDLC_DATA_O == $past(RX_FDL_BIT_I))
    else $error("data link bit lost");
endmodule
bind hcc_link_cfg hcc_link_cfg_assertions u_hcc_link_cfg_assertions (.*);

// ### test/hcc_line_model.sv
// model of the line side: link bit timing and received line data
// assumes: free-running link; changes on the falling clock edge
module hcc_line_model (
  input  wire        clk_i,
  output logic       tx_stb_o  = 1'b0,
  output logic       ext_o     = 1'b0,
  output logic       fdl_stb_o = 1'b0,
  output logic       fdl_bit_o = 1'b0,
  output logic       rx_stb_o  = 1'b0,
  output logic       rx_bit_o  = 1'b0,
  output logic [4:0] chan_o    = 5'h00,
  output logic [2:0] pos_o     = 3'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] cnt = 10'h000;  // one frame of 32 channels x 8 bits
  // bit 1 of each channel with chan msb set carries a one
  always @(negedge clk_i) begin
    cnt       <= cnt + 10'h001;
    tx_stb_o  <= cnt[2:0] == 3'h3;
    ext_o     <= cnt[5];
    fdl_stb_o <= cnt[3:0] == 4'h2;
    fdl_bit_o <= cnt[7];
    rx_stb_o  <= cnt[1:0] == 2'h1;
    rx_bit_o  <= cnt[4:2] == 3'h0 && cnt[9];
    pos_o     <= cnt[4:2];
    chan_o    <= cnt[9:5];
  end
endmodule

// ### test/tb_hcc_link_cfg.sv
// self-checking bench for the link code and channel configuration block
// assumes: line model and checker compiled before this file
module tb_hcc_link_cfg;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hdata = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, fdat, got, ns, no;
  logic [23:0] blk = 24'h120000;  // channels 17 and 20
  logic tstb, ext, fstb, fbit, rstb, rbit, tx, act, hstb, hbit;
  logic [4:0] chan;
  logic [2:0] pos;
  int errors = 0, cmp_count = 0, i, n;
  logic [7:0] ta [5] = '{8'h07, 8'h90, 8'h91, 8'h08, 8'h33};
  logic [7:0] tw [5] = '{8'h3f, 8'hff, 8'ha5, 8'h5a, 8'h77};
  logic [7:0] te [5] = '{8'h3f, 8'hbf, 8'ha5, 8'h00, 8'h00};
  logic [7:0] rc [4] = '{8'h3f, 8'h92, 8'h83, 8'ha3};
  logic [7:0] rs [4] = '{8'hff, 8'hfe, 8'h7f, 8'h00};
  logic [7:0] xs [4] = '{8'd64, 8'd1, 8'd1, 8'd16};
  logic [7:0] xo [4] = '{8'd32, 8'd1, 8'd0, 8'd2};
  always #20 clk = ~clk;
  always @(negedge clk) hdata <= ~hdata;
  hcc_line_model u_hcc_line_model (.clk_i(clk), .tx_stb_o(tstb),
    .ext_o(ext), .fdl_stb_o(fstb), .fdl_bit_o(fbit), .rx_stb_o(rstb),
    .rx_bit_o(rbit), .chan_o(chan), .pos_o(pos));
  hcc_link_cfg #(.CODE_REPEAT(8'd2)) u_hcc_link_cfg (.CLK_I(clk),
    .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .FIFO_DATA_O(fdat), .FIFO_WR_O(),
    .TX_BIT_STB_I(tstb), .EXT_LINK_DATA_I(ext), .HDLC_TX_DATA_I(hdata),
    .HDLC_TX_ADV_O(), .TX_LINK_DATA_O(tx), .CODE_ACTIVE_O(act),
    .RX_FDL_BIT_I(fbit), .RX_FDL_STB_I(fstb), .RX_DATA_I(rbit),
    .RX_BIT_STB_I(rstb), .RX_CHAN_I(chan), .RX_BIT_POS_I(pos),
    .RX_CHAN_BLOCK_I(blk), .RX_HDLC_DATA_O(hbit), .RX_HDLC_STB_O(hstb));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    rd = 1'b0;
    got = rdata;
  endtask
  // bounded wait for the next link bit strobe
  task automatic next_stb();
    @(negedge clk);
    for (n = 0; n < 40 && tstb !== 1'b1; n++) @(negedge clk);
    if (tstb !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 5; i++) begin
      rd_reg(ta[i]);
      chk("reset value", 8'h00, got);
      wr_reg(ta[i], tw[i]);
      if (ta[i] == 8'h08) chk("fifo byte", 8'h5a, fdat);
      rd_reg(ta[i]);
      chk("read back", te[i], got);
    end
    $display("test registers done");
    wr_reg(8'h07, 8'h45);
    next_stb();
    wr_reg(8'h07, 8'hc5);
    repeat (2) @(negedge clk);
    chk("code active", 8'h01, {7'h00, act});
    for (i = 0; i < 12; i++) begin
      next_stb();
      chk("code bit", {7'h00, i % 6 == 0 || i % 6 == 2}, {7'h00, tx});
    end
    chk("code done", 8'h00, {7'h00, act});
    wr_reg(8'h07, 8'hc5);
    repeat (3) @(negedge clk);
    chk("held trigger", 8'h00, {7'h00, act});
    wr_reg(8'h07, 8'h05);
    wr_reg(8'h07, 8'h85);
    repeat (2) @(negedge clk);
    chk("restart", 8'h01, {7'h00, act});
    for (i = 0; i < 8; i++) begin
      next_stb();
      chk("pin source", {7'h00, ext}, {7'h00, tx});
    end
    $display("test transmit done");
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h90, rc[i]);
      wr_reg(8'h91, rs[i]);
      repeat (4) @(negedge clk);
      {ns, no} = 16'h0000;
      repeat (1024) begin
        @(negedge clk);
        if (hstb === 1'b1) {ns, no} = {ns + 8'h01, no + {7'h00, hbit}};
      end
      chk("rx strobes", xs[i], ns);
      chk("rx ones", xo[i], no);
    end
    $display("test receive done");
    final_report();
  end
endmodule
